// ==== rtl/radio_rx_pkg.sv ====
// shared constants for the channel A receive status block
package radio_rx_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] CTRL_ADDR      = 6'h03;
  localparam logic [5:0] RX_STATUS_ADDR = 6'h08;
  localparam logic [5:0] RX_BYTE_A_ADDR = 6'h09;
  localparam logic [5:0] RX_VALID_A_ADDR = 6'h0A;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TX_ENABLE_BIT  = 7;
  localparam int RX_ENABLE_BIT  = 6;
  localparam int VALID_A_BIT    = 3;
  localparam int FLOW_A_BIT     = 2;
  localparam int EOF_A_BIT      = 1;
  localparam int FULL_A_BIT     = 0;
  // ---------------------------------------------------------------
  // reset values, valid mask and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] RX_BYTE_RESET  = 8'h00;
  localparam logic [7:0] RX_VALID_RESET = 8'h00;
  localparam logic [7:0] ALL_VALID      = 8'hFF;
  localparam int BYTE_BITS  = 8;
  localparam int FIFO_DEPTH = 16;
endpackage : radio_rx_pkg

// ==== rtl/rx_byte_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module rx_byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRead) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_r <= count_r + 1'b1;
      end else if (doRead && !doWrite) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : rx_byte_fifo

// ==== rtl/radio_rx_status_chan_a.sv ====
// channel A receive deserializer, byte register and status flags
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps
module radio_rx_status_chan_a
  import radio_rx_pkg::*;
#(
  parameter int DEPTH = radio_rx_pkg::FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [5:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic [7:0] eofBitTimes,
  input  wire logic       bitTick,
  input  wire logic       bitValid,
  input  wire logic       bitValue,
  output logic            txEnable,
  output logic            rxEnable
);
  import radio_rx_pkg::*;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (regWrite && regAddr == CTRL_ADDR) begin
      ctrl_r <= regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
    end else begin
      txEnable <= ctrl_r[TX_ENABLE_BIT];
      rxEnable <= ctrl_r[RX_ENABLE_BIT];
    end
  end

  logic rxMode;
  assign rxMode = ctrl_r[RX_ENABLE_BIT] && !ctrl_r[TX_ENABLE_BIT];

  // ---------------------------------------------------------------
  // bit deserializer
  // ---------------------------------------------------------------
  logic [7:0] shiftData_r;
  logic [7:0] shiftMask_r;
  logic [3:0] bitCount_r;
  logic [7:0] idleCount_r;
  logic       begun_r;
  logic       frameEnd;
  logic       byteDone;
  logic [7:0] lastData;
  logic [7:0] lastMask;
  logic       pushValid;
  logic [15:0] pushWord;
  logic       pushReady;

  // idle bit times counted only once begun
  assign frameEnd = rxMode && bitTick && !bitValid && begun_r && eofBitTimes != 8'h00
                    && (idleCount_r + 8'h01) >= eofBitTimes;
  assign byteDone = rxMode && bitTick && bitCount_r == 4'(BYTE_BITS - 1);

  // earliest bit lands in bit 0
  always_comb begin
    lastData = shiftData_r;
    lastMask = shiftMask_r;
    lastData[bitCount_r[2:0]] = bitValid ? bitValue : 1'b0;
    lastMask[bitCount_r[2:0]] = bitValid;
  end

  // partial bytes are flushed at frame end so the valid mask can show it
  assign pushValid = byteDone || (frameEnd && bitCount_r != 4'h0);
  assign pushWord  = byteDone ? {lastMask, lastData} : {shiftMask_r, shiftData_r};

  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      shiftData_r <= 8'h00;
      shiftMask_r <= 8'h00;
      bitCount_r  <= 4'h0;
    end else if (byteDone || frameEnd) begin
      shiftData_r <= 8'h00;
      shiftMask_r <= 8'h00;
      bitCount_r  <= 4'h0;
    end else if (bitTick && (begun_r || bitValid)) begin
      shiftData_r <= lastData;
      shiftMask_r <= lastMask;
      bitCount_r  <= bitCount_r + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      begun_r     <= 1'b0;
      idleCount_r <= 8'h00;
    end else if (frameEnd) begin
      begun_r     <= 1'b0;
      idleCount_r <= 8'h00;
    end else if (bitTick && bitValid) begin
      begun_r     <= 1'b1;
      idleCount_r <= 8'h00;
    end else if (bitTick && begun_r) begin
      idleCount_r <= idleCount_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // fifo between deserializer and byte register
  // ---------------------------------------------------------------
  logic [15:0] popWord;
  logic        popValid;
  logic        popReady;
  logic        full_r;

  // drains only while the byte register is empty, so it absorbs host latency
  assign popReady = !full_r;

  rx_byte_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock    (clock),
    .sys_rst  (sys_rst || !rxMode),
    .inData   (pushWord),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .outData  (popWord),
    .outValid (popValid),
    .outReady (popReady)
  );

  // ---------------------------------------------------------------
  // byte register and flags
  // ---------------------------------------------------------------
  logic [7:0] rxByte_r;
  logic [7:0] rxValid_r;
  logic       validA_r;
  logic       flowA_r;
  logic       eofA_r;
  logic       load;
  logic       hostByteRead;
  logic       statusRead;
  logic       overflow;
  logic       underflow;

  assign load         = popValid && popReady;
  assign hostByteRead = regRead && regAddr == RX_BYTE_A_ADDR;
  assign statusRead   = regRead && regAddr == RX_STATUS_ADDR;
  // lost byte when the buffer cannot take it
  assign overflow     = pushValid && !pushReady;
  assign underflow    = hostByteRead && !full_r && !load;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxByte_r  <= RX_BYTE_RESET;
      rxValid_r <= RX_VALID_RESET;
    end else if (load) begin
      rxByte_r  <= popWord[7:0];
      rxValid_r <= popWord[15:8];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      validA_r <= 1'b0;
    end else if (load) begin
      validA_r <= (popWord[15:8] == ALL_VALID);
    end
  end

  // full on transfer, set wins over the clearing read
  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      full_r <= 1'b0;
    end else if (load) begin
      full_r <= 1'b1;
    end else if (hostByteRead) begin
      full_r <= 1'b0;
    end
  end

  // set regardless of any interrupt enable, cleared by status read
  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      flowA_r <= 1'b0;
    end else if (overflow || underflow) begin
      flowA_r <= 1'b1;
    end else if (statusRead) begin
      flowA_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || !rxMode) begin
      eofA_r <= 1'b0;
    end else if (frameEnd) begin
      eofA_r <= 1'b1;
    end else if (statusRead) begin
      eofA_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] statusWord;

  always_comb begin
    statusWord = 8'h00;
    statusWord[VALID_A_BIT] = validA_r;
    statusWord[FLOW_A_BIT]  = flowA_r;
    statusWord[EOF_A_BIT]   = eofA_r;
    statusWord[FULL_A_BIT]  = full_r;
  end

  // only the control register takes writes
  // receive status reads zero outside receive mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (!regRead) begin
        regRdData <= 8'h00;
      end else begin
        unique case (regAddr)
          CTRL_ADDR:       regRdData <= ctrl_r;
          RX_STATUS_ADDR:  regRdData <= rxMode ? statusWord : 8'h00;
          RX_BYTE_A_ADDR:  regRdData <= rxByte_r;
          RX_VALID_A_ADDR: regRdData <= rxValid_r;
          default:         regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule : radio_rx_status_chan_a

// ==== test/radio_rx_status_monitor.sv ====
// concurrent checks on the channel A status block ports
`timescale 1ns/10ps
module radio_rx_status_monitor
  import radio_rx_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [5:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic       txEnable,
  input wire logic       rxEnable
);
  // ---------------------------------------------------------------
  // last control value written by the host
  // ---------------------------------------------------------------
  logic wantTx_r;
  logic wantRx_r;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wantTx_r <= 1'b0;
      wantRx_r <= 1'b0;
    end else if (regWrite && regAddr == CTRL_ADDR) begin
      wantTx_r <= regWrData[TX_ENABLE_BIT];
      wantRx_r <= regWrData[RX_ENABLE_BIT];
    end
  end
  wire ctrlSettled = (rxEnable == wantRx_r) && (txEnable == wantTx_r);
  wire statusRd    = regRead && regAddr == RX_STATUS_ADDR;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_read_answer_pulse: assert property (regRead |=> regRdValid)
    else $error("read strobe got no answer");
  a_no_stray_answer: assert property (!regRead |=> !regRdValid && regRdData == 8'h00)
    else $error("read answer without a read");
  a_ctrl_copy_follows: assert property (regWrite && regAddr == CTRL_ADDR ##1 !regWrite |-> ##1 ctrlSettled)
    else $error("enable outputs do not follow control write");
  a_ctrl_read_back: assert property (regRead && regAddr == CTRL_ADDR |=> regRdData[7:6] == {wantTx_r, wantRx_r})
    else $error("control readback wrong");
  a_status_zero_idle: assert property (statusRd && ctrlSettled && !(wantRx_r && !wantTx_r) |=> regRdData == 8'h00)
    else $error("status nonzero outside receive mode");
  a_status_high_clear: assert property (statusRd |=> regRdData[7:4] == 4'h0)
    else $error("unused status bits set");
  a_unmapped_zero: assert property (regRead && regAddr > RX_VALID_A_ADDR |=> regRdData == 8'h00)
    else $error("unmapped read nonzero");
  a_write_no_answer: assert property (regWrite && !regRead |=> !regRdValid)
    else $error("write produced a read answer");
  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_full_seen: cover property (statusRd ##1 regRdData[FULL_A_BIT]);
  c_flow_seen: cover property (statusRd ##1 regRdData[FLOW_A_BIT]);
  c_eof_seen: cover property (statusRd ##1 regRdData[EOF_A_BIT]);
endmodule : radio_rx_status_monitor

bind radio_rx_status_chan_a radio_rx_status_monitor radio_rx_status_monitor_i (.clock(clock), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
  .regRdValid(regRdValid), .txEnable(txEnable), .rxEnable(rxEnable));

// ==== test/rx_bit_source.sv ====
// behavioural radio front end feeding channel A bits
`timescale 1ns/10ps
module rx_bit_source (
  input wire logic clock,
  output logic     bitTick,
  output logic     bitValid,
  output logic     bitValue
);
  initial begin
    bitTick  = 1'b0;
    bitValid = 1'b0;
    bitValue = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      bitTick  = 1'b1;
      bitValid = m[i];
      bitValue = d[i];
      @(negedge clock);
      bitTick  = 1'b0;
      bitValid = 1'b0;
      // stale bit must not look valid between ticks
      bitValue = ~bitValue;
      repeat (2) @(negedge clock);
    end
  endtask : send
endmodule : rx_bit_source

// ==== test/testbench.sv ====
// self-checking bench for the channel A status block
`timescale 1ns/10ps
module testbench;
  import radio_rx_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] regAddr = 6'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [7:0] eofBitTimes = 8'h00;
  logic bitTick, bitValid, bitValue;
  int errorCnt = 0;
  int samplesChecked = 0;
  int cycleCnt = 0;
  always #12.5 clock = ~clock;
  // small fifo so overflow is reachable quickly
  radio_rx_status_chan_a #(.DEPTH(2)) radio_rx_status_chan_a_i (.clock(clock), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .eofBitTimes(eofBitTimes), .bitTick(bitTick), .bitValid(bitValid),
    .bitValue(bitValue), .txEnable(), .rxEnable());
  rx_bit_source rx_bit_source_i (.clock(clock), .bitTick(bitTick), .bitValid(bitValid), .bitValue(bitValue));
  // ---------------------------------------------------------------
  // host access tasks
  // ---------------------------------------------------------------
  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : testDone
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    samplesChecked++;
    if (regRdValid !== 1'b1 || regRdData !== e) begin
      errorCnt++;
      $display("mismatch at %0t: addr %h got %h want %h", $time, a, regRdData, e);
    end
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  // hang guard, whole run needs well under 2000 cycles
  always @(posedge clock) begin
    cycleCnt++;
    if (cycleCnt == 20000) begin
      errorCnt++;
      $display("mismatch at %0t: timeout", $time);
      testDone();
    end
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    rd(RX_BYTE_A_ADDR, 8'h00);
    rd(RX_STATUS_ADDR, 8'h00);
    $display("test reset values done");
    wr(CTRL_ADDR, 8'h40);
    wr(RX_BYTE_A_ADDR, 8'h5A);
    wr(RX_STATUS_ADDR, 8'h0F);
    idle(3);
    rd(CTRL_ADDR, 8'h40);
    rd(RX_STATUS_ADDR, 8'h00);
    rx_bit_source_i.send(8'hA5, 8'hFF, 8);
    idle(3);
    rd(RX_STATUS_ADDR, 8'h09);
    rd(RX_BYTE_A_ADDR, 8'hA5);
    rd(RX_BYTE_A_ADDR, 8'hA5);
    rd(RX_STATUS_ADDR, 8'h0C);
    rd(RX_STATUS_ADDR, 8'h08);
    $display("test single byte done");
    for (int k = 1; k <= 4; k++) rx_bit_source_i.send(8'(k * 17), 8'hFF, 8);
    idle(3);
    rd(RX_STATUS_ADDR, 8'h0D);
    for (int k = 1; k <= 3; k++) begin
      rd(RX_BYTE_A_ADDR, 8'(k * 17));
      idle(3);
    end
    rd(RX_STATUS_ADDR, 8'h08);
    $display("test overflow done");
    eofBitTimes = 8'h03;
    rx_bit_source_i.send(8'h0D, 8'h0F, 7);
    idle(3);
    rd(RX_STATUS_ADDR, 8'h03);
    rd(RX_BYTE_A_ADDR, 8'h0D);
    rd(RX_VALID_A_ADDR, 8'h0F);
    $display("test end of frame done");
    rx_bit_source_i.send(8'h3C, 8'hFF, 8);
    idle(3);
    wr(CTRL_ADDR, 8'hC0);
    idle(4);
    rd(RX_STATUS_ADDR, 8'h00);
    rd(6'h3F, 8'h00);
    wr(CTRL_ADDR, 8'h00);
    idle(4);
    rd(RX_STATUS_ADDR, 8'h00);
    rd(RX_BYTE_A_ADDR, 8'h3C);
    $display("test mode gating done");
    testDone();
  end
endmodule : testbench
